// file: rtl/acc_pkg.sv
// Shared constants and carrier types for the comparator control block
package acc_pkg;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_SHARED = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] SHARED_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK   = 8'hBF;
	localparam int BIT_ON     = 7;
	localparam int BIT_RESULT = 6;
	localparam int BIT_DRIVE  = 5;
	localparam int BIT_INVERT = 4;
	localparam int BIT_SPEED  = 3;
	localparam int BIT_REF    = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       cmp1_on;
		logic       cmp1_pin_drive;
		logic       cmp1_invert;
		logic       cmp1_speed_sel;
		logic       cmp1_ref_sel;
		logic [1:0] cmp1_chan_sel;
	} acc_ctrl_type;

	typedef struct packed {
		logic       core_enable;
		logic       speed_normal;
		logic       noninv_is_ref;
		logic [3:0] inv_src_onehot;
		logic       ref_enable;
	} acc_core_type;
endpackage

// file: rtl/acc_result.sv
// Result qualification: polarity, off-state level and pin drive gating
`timescale 1ns/1ps
`default_nettype none
module acc_result (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire acc_pkg::acc_ctrl_type ctrl,
	input  wire logic                raw_gt,
	input  wire logic                pin_dir_out,
	output logic                     result,
	output logic                     pin_val,
	output logic                     pin_oe
);
	logic result_ff, pin_val_ff, pin_oe_ff;
	logic nxt_result, nxt_pin_val, nxt_pin_oe;

	always_comb begin
		if (ctrl.cmp1_on)
			nxt_result = raw_gt ^ ctrl.cmp1_invert;
		else
			nxt_result = ctrl.cmp1_invert;
		nxt_pin_oe  = ctrl.cmp1_pin_drive & ctrl.cmp1_on & pin_dir_out;
		nxt_pin_val = nxt_pin_oe & nxt_result;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_ff  <= 1'b0;
			pin_val_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
		end else begin
			result_ff  <= nxt_result;
			pin_val_ff <= nxt_pin_val;
			pin_oe_ff  <= nxt_pin_oe;
		end
	end

	assign result  = result_ff;
	assign pin_val = pin_val_ff;
	assign pin_oe  = pin_oe_ff;

	a_off_level: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl.cmp1_on |=> result_ff == $past(ctrl.cmp1_invert))
		else $error("off result not polarity level");
	a_pin_gate: assert property (@(posedge clk) disable iff (!rst_n)
		pin_oe_ff |-> $past(ctrl.cmp1_on && ctrl.cmp1_pin_drive && pin_dir_out))
		else $error("pin driven without all enables");
endmodule
`default_nettype wire

// file: rtl/acc_top.sv
// Comparator 1 control register, AXI4-Lite slave and core steering
`timescale 1ns/1ps
`default_nettype none
module acc_top (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        raw_gt,
	input  wire logic        pin_direction,
	output logic             cmp1_result_pin,
	output logic             cmp1_result_pin_oe,
	output acc_pkg::acc_core_type core_ctrl,
	output logic [7:0]       comparator_shared_control
);
	function automatic logic [3:0] onehot4(input logic [1:0] code);
		onehot4 = 4'h1 << code;
	endfunction

	logic [7:0]  ctrl_ff, nxt_ctrl;
	logic [7:0]  shared_ff, nxt_shared;
	logic        aw_ff, w_ff, nxt_aw, nxt_w;
	logic [3:0]  awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff, nxt_bresp;
	logic        rvalid_ff, nxt_rvalid;
	logic [1:0]  rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	acc_pkg::acc_core_type core_ff, nxt_core;
	acc_pkg::acc_ctrl_type ctrl_s;
	logic result_w, pin_val_w, pin_oe_w;
	logic do_write;

	always_comb begin
		ctrl_s.cmp1_on        = ctrl_ff[acc_pkg::BIT_ON];
		ctrl_s.cmp1_pin_drive = ctrl_ff[acc_pkg::BIT_DRIVE];
		ctrl_s.cmp1_invert    = ctrl_ff[acc_pkg::BIT_INVERT];
		ctrl_s.cmp1_speed_sel = ctrl_ff[acc_pkg::BIT_SPEED];
		ctrl_s.cmp1_ref_sel   = ctrl_ff[acc_pkg::BIT_REF];
		ctrl_s.cmp1_chan_sel  = ctrl_ff[1:0];
	end

	acc_result u_result (
		.clk         (clk),
		.rst_n       (rst_n),
		.ctrl        (ctrl_s),
		.raw_gt      (raw_gt),
		.pin_dir_out (pin_direction),
		.result      (result_w),
		.pin_val     (pin_val_w),
		.pin_oe      (pin_oe_w)
	);

	// Write path: address and data latched in either order
	always_comb begin
		nxt_aw     = aw_ff;
		nxt_w      = w_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_shared = shared_ff;
		do_write   = aw_ff && w_ff && !bvalid_ff;
		if (s_axi_awvalid && !aw_ff) begin
			nxt_aw     = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_ff) begin
			nxt_w     = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw     = 1'b0;
			nxt_w      = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = acc_pkg::RESP_OKAY;
			case (awaddr_ff)
				acc_pkg::ADDR_CTRL: begin
					if (wstrb_ff[0])
						nxt_ctrl = wdata_ff[7:0] & acc_pkg::CTRL_WMASK;
				end
				acc_pkg::ADDR_SHARED: begin
					if (wstrb_ff[0])
						nxt_shared = wdata_ff[7:0];
				end
				acc_pkg::ADDR_STATUS: nxt_bresp = acc_pkg::RESP_OKAY;
				default: nxt_bresp = acc_pkg::RESP_SLVERR;
			endcase
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	// Read path: one cycle after address acceptance
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (rvalid_ff) begin
			if (s_axi_rready)
				nxt_rvalid = 1'b0;
		end else if (s_axi_arvalid) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = acc_pkg::RESP_OKAY;
			nxt_rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				acc_pkg::ADDR_CTRL: begin
					nxt_rdata[7:0] = ctrl_ff;
					nxt_rdata[acc_pkg::BIT_RESULT] = result_w;
				end
				acc_pkg::ADDR_SHARED: nxt_rdata[7:0] = shared_ff;
				acc_pkg::ADDR_STATUS: nxt_rdata[0] = result_w;
				default: nxt_rresp = acc_pkg::RESP_SLVERR;
			endcase
		end
	end

	// Steering of the analog core
	always_comb begin
		nxt_core.core_enable    = ctrl_ff[acc_pkg::BIT_ON];
		nxt_core.speed_normal   = ctrl_ff[acc_pkg::BIT_SPEED];
		nxt_core.noninv_is_ref  = ctrl_ff[acc_pkg::BIT_REF];
		nxt_core.inv_src_onehot = onehot4(ctrl_ff[1:0]);
		nxt_core.ref_enable     = ctrl_ff[acc_pkg::BIT_ON] & ctrl_ff[acc_pkg::BIT_REF];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff   <= acc_pkg::CTRL_RESET;
			shared_ff <= acc_pkg::SHARED_RESET;
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 4'h0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'h0;
			rvalid_ff <= 1'b0;
			rresp_ff  <= 2'h0;
			rdata_ff  <= 32'h0000_0000;
			// Core off, but code 00 still selects source 0
			core_ff   <= '{inv_src_onehot: 4'h1, default: 1'b0};
		end else begin
			ctrl_ff   <= nxt_ctrl;
			shared_ff <= nxt_shared;
			aw_ff     <= nxt_aw;
			w_ff      <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
			core_ff   <= nxt_core;
		end
	end

	assign s_axi_awready = !aw_ff;
	assign s_axi_wready  = !w_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign core_ctrl     = core_ff;
	assign comparator_shared_control = shared_ff;
	assign cmp1_result_pin    = pin_val_w;
	assign cmp1_result_pin_oe = pin_oe_w;

	a_core_enable: assert property (@(posedge clk) disable iff (!rst_n)
		core_ff.core_enable == $past(ctrl_ff[acc_pkg::BIT_ON]))
		else $error("core enable not following on bit");
	a_speed_sel: assert property (@(posedge clk) disable iff (!rst_n)
		core_ff.speed_normal == $past(ctrl_ff[acc_pkg::BIT_SPEED]))
		else $error("speed select mismatch");
	a_ref_sel: assert property (@(posedge clk) disable iff (!rst_n)
		core_ff.noninv_is_ref == $past(ctrl_ff[acc_pkg::BIT_REF]))
		else $error("reference select mismatch");
	a_chan_map: assert property (@(posedge clk) disable iff (!rst_n)
		$past(ctrl_ff[1:0]) == 2'h2 |-> core_ff.inv_src_onehot == 4'h4)
		else $error("channel code 2 not source 2");
	a_chan_onehot: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot(core_ff.inv_src_onehot))
		else $error("inverting source not one-hot");
	a_result_pol: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_s.cmp1_on && $stable(ctrl_ff) |=>
			result_w == ($past(raw_gt) ^ $past(ctrl_s.cmp1_invert)))
		else $error("result polarity wrong");
	a_invert_off: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_s.cmp1_on ##1 !ctrl_s.cmp1_on |-> result_w == $past(ctrl_s.cmp1_invert))
		else $error("invert bit not reflected");
	a_result_ro: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_ff[acc_pkg::BIT_RESULT])
		else $error("stored result bit not zero");
	a_ref_off: assert property (@(posedge clk) disable iff (!rst_n)
		core_ff.ref_enable |-> core_ff.core_enable)
		else $error("reference on while comparator off");
	a_pin_drive: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_s.cmp1_pin_drive ##1 !ctrl_s.cmp1_pin_drive |-> !cmp1_result_pin_oe)
		else $error("pin driven with drive bit clear");
endmodule
`default_nettype wire

// file: dv/acc_core_model.sv
// Behavioural model of the analog comparator core and its input selectors
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire acc_pkg::acc_core_type core_ctrl,
	input  wire logic [7:0]            v_pos,
	input  wire logic [7:0]            v_ref,
	input  wire logic [31:0]           v_inv,
	output logic                       raw_gt
);
	logic [7:0] v_plus;
	logic [7:0] v_minus;
	always_comb begin
		v_plus = core_ctrl.noninv_is_ref ? v_ref : v_pos;
		v_minus = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (core_ctrl.inv_src_onehot[i]) v_minus = v_inv[8*i +: 8];
		end
	end
	// An unpowered core or reference gives a toggling, meaningless answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) raw_gt <= 1'b0;
		else if (core_ctrl.core_enable && (!core_ctrl.noninv_is_ref || core_ctrl.ref_enable))
			raw_gt <= v_plus > v_minus;
		else raw_gt <= ~raw_gt;
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Register-level testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
	logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, raw_gt, pin_dir, pin, pin_oe;
	logic        gt, res, drv;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, v_inv;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  shared, v_pos, v_ref, c;
	acc_pkg::acc_core_type core;
	int          n_errors, num_checks;
	acc_top DUT (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.raw_gt(raw_gt), .pin_direction(pin_dir), .cmp1_result_pin(pin),
		.cmp1_result_pin_oe(pin_oe), .core_ctrl(core), .comparator_shared_control(shared)
	);
	acc_core_model core_model (
		.clk(clk), .rst_n(rst_n), .core_ctrl(core), .v_pos(v_pos), .v_ref(v_ref),
		.v_inv(v_inv), .raw_gt(raw_gt)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic results();
		if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (i == 40) n_errors++;
		if (i == 40) results();
		bready <= 1'b0;
		r = bresp;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (i == 40) n_errors++;
		if (i == 40) results();
		rready <= 1'b0;
		`CHK(rresp, er)
		if (er === acc_pkg::RESP_OKAY) `CHK(rdata, {24'h000000, e})
	endtask
	initial begin
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, pin_dir} = 6'h00;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		v_pos = 8'h64;
		v_ref = 8'h32;
		v_inv = {8'hC8, 8'h78, 8'h50, 8'h1E};
		n_errors = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc(acc_pkg::ADDR_CTRL, 8'h00, acc_pkg::RESP_OKAY);
		`CHK({core, pin_oe}, 9'h004)
		wr(acc_pkg::ADDR_SHARED, 8'hA5, rs);
		rdc(acc_pkg::ADDR_SHARED, 8'hA5, acc_pkg::RESP_OKAY);
		wr(acc_pkg::ADDR_CTRL, 8'hBF, rs);
		// Reset in mid-run with everything switched on
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(acc_pkg::ADDR_CTRL, 8'h00, acc_pkg::RESP_OKAY);
		rdc(acc_pkg::ADDR_SHARED, 8'h00, acc_pkg::RESP_OKAY);
		`CHK({core, shared}, 16'h0200)
		for (int k = 0; k < 16; k++) begin
			drv = k[0] | k[2];
			c = {2'b11, drv, k[3], k[0] ^ k[3], k[2], k[1:0]};
			pin_dir <= k[1] ^ k[2];
			wr(acc_pkg::ADDR_CTRL, c, rs);
			repeat (4) @(posedge clk);
			gt = (k[2] ? v_ref : v_pos) > v_inv[8*k[1:0] +: 8];
			res = gt ^ k[3];
			rdc(acc_pkg::ADDR_CTRL, {1'b1, res, c[5:0]}, acc_pkg::RESP_OKAY);
			rdc(acc_pkg::ADDR_STATUS, {7'h00, res}, acc_pkg::RESP_OKAY);
			`CHK(core, {1'b1, c[3], c[2], 4'h1 << c[1:0], c[2]})
			`CHK({pin_oe, pin}, {drv & pin_dir, drv & pin_dir & res})
		end
		for (int k = 0; k < 2; k++) begin
			c = {2'b01, 1'b1, k[0], 4'hF};
			pin_dir <= 1'b1;
			wr(acc_pkg::ADDR_CTRL, c, rs);
			repeat (4) @(posedge clk);
			rdc(acc_pkg::ADDR_CTRL, {1'b0, k[0], c[5:0]}, acc_pkg::RESP_OKAY);
			`CHK({core.core_enable, core.ref_enable, pin_oe}, 3'h0)
		end
		// Status writes are ignored; a write without lane 0 changes nothing
		wr(acc_pkg::ADDR_STATUS, 8'hFF, rs);
		`CHK(rs, acc_pkg::RESP_OKAY)
		wstrb <= 4'hE;
		wr(acc_pkg::ADDR_CTRL, 8'h00, rs);
		wstrb <= 4'hF;
		rdc(acc_pkg::ADDR_CTRL, 8'h7F, acc_pkg::RESP_OKAY);
		wr(4'hC, 8'h12, rs);
		`CHK(rs, acc_pkg::RESP_SLVERR)
		rdc(4'hC, 8'h00, acc_pkg::RESP_SLVERR);
		rdc(acc_pkg::ADDR_CTRL, 8'h7F, acc_pkg::RESP_OKAY);
		results();
	end
endmodule
`default_nettype wire
